//--- pkg/afc_cfg.svh
`ifndef AFC_CFG_SVH
`define AFC_CFG_SVH
// ============================================================
// Data word and FIFO shape.
`define AFC_DW         12
`define AFC_DEPTH      8
`define AFC_FIFO_RST   12'h800
// ============================================================
// Status/control bit positions.
`define AFC_B_ALMOST_FULL_FLAG_N     11
`define AFC_B_CNT_HI   10
`define AFC_B_CNT_LO   8
`define AFC_B_DIS      7
`define AFC_B_RST      6
`define AFC_B_BUS_ENABLE_DURING_BUSY     5
`define AFC_B_EMP      4
`define AFC_B_SOOR     3
// ============================================================
// Timing; busy and conversion cycles derived from the 10 ns clock period, strobe length fixed.
`define AFC_CLK_NS     10
`define AFC_BUSY_NS    100
`define AFC_BUSY_CYC   ((`AFC_BUSY_NS + `AFC_CLK_NS - 1) / `AFC_CLK_NS)
`define AFC_CONV_NS    7000
`define AFC_CONV_CYC   (`AFC_CONV_NS / `AFC_CLK_NS)
`define AFC_STROBE_CYC 3
// ============================================================
// Host Wishbone register offsets and command bits.
`define AFC_WB_CMD     4'h0
`define AFC_WB_WDATA   4'h4
`define AFC_WB_RDATA   4'h8
`define AFC_WB_STAT    4'hc
`define AFC_CMD_CONV   0
`define AFC_CMD_RDFIFO 1
`define AFC_CMD_RDSTAT 2
`define AFC_CMD_WRCTRL 3
`define AFC_CMD_RESET  4
`endif

//--- pkg/afc_pkg.sv
// ============================================================
// Shared state types.
package afc_pkg;
	// Converter sequence states.
	typedef enum logic [2:0] {
		CV_IDLE = 3'b001,
		CV_HOLD = 3'b010,
		CV_CONV = 3'b100
	} afc_cv_t;
	// Host bus cycle states.
	typedef enum logic [2:0] {
		HS_IDLE = 3'b001,
		HS_STRB = 3'b010,
		HS_RCVR = 3'b100
	} afc_hs_t;
endpackage

//--- pkg/afc_link_if.sv
// ============================================================
// Parallel link between processor and converter.
interface afc_link_if;
	logic        conversion_start_n; // Rising edge starts a conversion.
	logic        reset_n;            // Active-low converter reset.
	logic        cs_n;               // Active-low chip select.
	logic        read_strobe_n;      // Active-low read strobe.
	logic        write_strobe_n;     // Active-low write strobe.
	logic        register_select;    // High selects the status/control register.
	logic        busy_n;             // Low while the track/hold settles.
	logic        almost_full_flag_n; // Low when the programmed count is reached.
	logic [11:0] host_data_out;      // Host drive value.
	logic        host_data_oe_n;     // Low while the host drives.
	logic [11:0] dev_data_out;       // Converter drive value.
	logic        dev_data_oe_n;      // Low while the converter drives.
	logic [11:0] data_bus;           // Resolved bus level.
	// Resolve the shared bus from both enables; a released bus rests at its pull-up level.
	assign data_bus = !dev_data_oe_n ? dev_data_out : (!host_data_oe_n ? host_data_out : 12'hfff);
	modport dev (input conversion_start_n, reset_n, cs_n, read_strobe_n, write_strobe_n, register_select,
		data_bus, output busy_n, almost_full_flag_n, dev_data_out, dev_data_oe_n);
	modport host (output conversion_start_n, reset_n, cs_n, read_strobe_n, write_strobe_n, register_select,
		host_data_out, host_data_oe_n, input busy_n, almost_full_flag_n, data_bus);
endinterface

//--- rtl/afc_dev.sv
// Function
// [R1] Start edge holds sample, begins conversion.
// [R2] Start edge is asynchronous, never bus-gated.
// [R3] Reset loads every FIFO word with 800.
// [R4] Reset clears flag output and register.
// [R5] Conversion timed from the converter clock.
// [R6] Register uses all twelve data lines.
// [R7] Host holds select high for register access.
// [R8] Register write sets flag, bus, reset.
// [R9] Host programs register at power-up.
// [R10] Each conversion bumps pointer, compares count.
// [R11] Flag asserts at count unless disabled.
// [R12] Threshold programmable from one to eight.
// [R13] Register readable anytime with pointer, status.
// [R14] Register read never moves FIFO data.
// [R15] Host reads status before data word.
// [R16] Select low reads location 0, high register.
// [R17] Read below threshold releases the flag.
// [R18] Bit 7 set disables flag and status.
// [R19] Bit 5 clear blocks bus during busy.
// [R20] Start edge synchronised through flip-flops.
// [R21] Disable write releases flag next edge.
//
// Implementation choices: the Wishbone slave port and the register offsets.
`include "afc_cfg.svh"
module afc_dev #(
	parameter int BUSY_CYC = `AFC_BUSY_CYC, // Track/hold settle cycles.
	parameter int CONV_CYC = `AFC_CONV_CYC  // Conversion cycles.
) (
	// Clock and reset.
	input  wire logic               REF_CLK_I,
	input  wire logic               RST_I,
	// Analog front end sample.
	input  wire logic [`AFC_DW-1:0] SAMPLE_I,
	input  wire logic               SAMPLE_OOR_I,
	output      logic               HOLD_O,
	// Processor link.
	afc_link_if.dev                 lnk
);
	localparam int PW = $clog2(`AFC_DEPTH + 1);
	// ============================================================
	// Start synchroniser.
	logic          cst_s1_ff;    // First stage, read only by the second.
	logic          cst_s2_ff;    // Second stage.
	logic          cst_s3_ff;    // Third stage.
	logic          cst_lvl_ff;   // Agreed level.
	logic          start;        // Rising start edge.
	// Three stages; the edge counts once stages two and three agree.
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			cst_s1_ff  <= 1'b1;
			cst_s2_ff  <= 1'b1;
			cst_s3_ff  <= 1'b1;
			cst_lvl_ff <= 1'b1;
		end else begin
			cst_s1_ff <= lnk.conversion_start_n; // [R2] [R20]
			cst_s2_ff <= cst_s1_ff;
			cst_s3_ff <= cst_s2_ff;
			if (cst_s2_ff == cst_s3_ff) begin
				cst_lvl_ff <= cst_s3_ff;
			end
		end
	end
	// A start is recognised with no regard to chip select or strobes.
	assign start = cst_s2_ff && cst_s3_ff && !cst_lvl_ff; // [R2] [R20]
	// ============================================================
	// Bus strobes and control register.
	logic          rd_ff;        // Read active last cycle.
	logic          wr_ff;        // Write active last cycle.
	logic          sel_ff;       // Select latched at read start.
	logic          rd;           // Read active now.
	logic          wr;           // Register write active now.
	logic          wr_go;        // First cycle of a register write.
	logic [2:0]    cnt_sel_ff;   // Almost-full word count code.
	logic          dis_ff;       // Almost-full disable.
	logic          bus_enable_during_busy_ff;      // Bus enable during busy.
	logic          soft_rst_ff;  // Reset request from bit 6.
	logic          clr;          // FIFO and register clear.
	assign rd    = !lnk.cs_n && !lnk.read_strobe_n;
	assign wr    = !lnk.cs_n && !lnk.write_strobe_n && lnk.register_select; // [R7]
	assign wr_go = wr && !wr_ff;
	assign clr   = !lnk.reset_n || soft_rst_ff; // [R3] [R4]
	// Strobe history for edge detection.
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			rd_ff  <= 1'b0;
			wr_ff  <= 1'b0;
			sel_ff <= 1'b0;
		end else begin
			rd_ff <= rd;
			wr_ff <= wr;
			if (rd && !rd_ff) begin
				sel_ff <= lnk.register_select;
			end
		end
	end
	// Register write takes bits 10 to 5 of the bus on its first cycle.
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			cnt_sel_ff  <= 3'h0;
			dis_ff      <= 1'b0;
			bus_enable_during_busy_ff     <= 1'b0;
			soft_rst_ff <= 1'b0;
		end else if (clr) begin
			cnt_sel_ff  <= 3'h0; // [R4]
			dis_ff      <= 1'b0;
			bus_enable_during_busy_ff     <= 1'b0;
			soft_rst_ff <= 1'b0;
		end else if (wr_go) begin
			cnt_sel_ff  <= lnk.data_bus[`AFC_B_CNT_HI:`AFC_B_CNT_LO]; // [R6] [R8] [R12]
			dis_ff      <= lnk.data_bus[`AFC_B_DIS];  // [R8] [R18]
			bus_enable_during_busy_ff     <= lnk.data_bus[`AFC_B_BUS_ENABLE_DURING_BUSY]; // [R8] [R19]
			soft_rst_ff <= lnk.data_bus[`AFC_B_RST];  // [R8]
		end
	end
	// ============================================================
	// Conversion sequencer.
	afc_pkg::afc_cv_t cv_ff;     // Sequence state.
	logic [12:0]   tmr_ff;       // Cycle timer.
	logic [12:0]   word_ff;      // Held sample with range bit.
	logic          push;         // Conversion complete.
	assign push = (cv_ff == afc_pkg::CV_CONV) && (tmr_ff == 13'h0);
	logic          busy_nxt;     // Busy in the coming cycle, shared by busy pin and bus drive.
	assign busy_nxt = start || (cv_ff == afc_pkg::CV_HOLD && tmr_ff != 13'h0);
	// A new start always restarts the sequence, even mid-conversion.
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			cv_ff   <= afc_pkg::CV_IDLE;
			tmr_ff  <= 13'h0;
			word_ff <= 13'h0;
		end else if (start) begin
			cv_ff   <= afc_pkg::CV_HOLD; // [R1]
			tmr_ff  <= 13'(BUSY_CYC - 1);
			word_ff <= {SAMPLE_OOR_I, SAMPLE_I};
		end else begin
			unique case (cv_ff)
				afc_pkg::CV_IDLE: begin
					cv_ff <= afc_pkg::CV_IDLE;
				end
				afc_pkg::CV_HOLD: begin
					// Busy time elapses, then bit trials run.
					if (tmr_ff == 13'h0) begin
						cv_ff  <= afc_pkg::CV_CONV;
						tmr_ff <= 13'(CONV_CYC - 1); // [R5]
					end else begin
						tmr_ff <= tmr_ff - 13'h1;
					end
				end
				afc_pkg::CV_CONV: begin
					if (tmr_ff == 13'h0) begin
						cv_ff <= afc_pkg::CV_IDLE;
					end else begin
						tmr_ff <= tmr_ff - 13'h1; // [R5]
					end
				end
			endcase
		end
	end
	// Track/hold and busy outputs follow the sequencer.
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			HOLD_O     <= 1'b0;
			lnk.busy_n <= 1'b1;
		end else begin
			HOLD_O     <= start || (cv_ff != afc_pkg::CV_IDLE && !push); // [R1]
			lnk.busy_n <= !busy_nxt;
		end
	end
	// ============================================================
	// FIFO storage.
	logic [12:0]   mem_ff [`AFC_DEPTH]; // Words, location 0 at the bottom.
	logic [PW-1:0] ptr_ff;       // Number of stored words.
	logic [PW-1:0] nxt_ptr;      // Pointer after this cycle.
	logic          pop;          // Data word read completed.
	logic          wr_ok;        // Push has room.
	logic          ovr_ff;       // Sticky overrun.
	logic [`AFC_DEPTH-1:0] oor_v; // Range bit of each valid word.
	// A data read completes on strobe release; register reads never pop.
	assign pop   = rd_ff && !rd && !sel_ff && (ptr_ff != '0); // [R14] [R16]
	assign wr_ok = push && ((ptr_ff != PW'(`AFC_DEPTH)) || pop);
	always_comb begin
		nxt_ptr = ptr_ff;
		if (wr_ok && !pop) begin
			nxt_ptr = ptr_ff + PW'(1); // [R10]
		end else if (pop && !wr_ok) begin
			nxt_ptr = ptr_ff - PW'(1);
		end
	end
	// Each location shifts down on a pop and takes the new word at the top.
	genvar gi;
	generate
		for (gi = 0; gi < `AFC_DEPTH; gi++) begin : g_loc
			always_ff @(posedge REF_CLK_I or posedge RST_I) begin
				if (RST_I) begin
					mem_ff[gi] <= {1'b0, `AFC_FIFO_RST};
				end else if (clr) begin
					mem_ff[gi] <= {1'b0, `AFC_FIFO_RST}; // [R3]
				end else if (wr_ok && PW'(gi) == nxt_ptr - PW'(1)) begin
					mem_ff[gi] <= word_ff;
				end else if (pop) begin
					mem_ff[gi] <= (gi < `AFC_DEPTH - 1) ? mem_ff[(gi + 1) % `AFC_DEPTH] : {1'b0, `AFC_FIFO_RST};
				end
			end
			assign oor_v[gi] = mem_ff[gi][12] && (PW'(gi) < ptr_ff);
		end
	endgenerate
	// Pointer and overrun bookkeeping.
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			ptr_ff <= '0;
			ovr_ff <= 1'b0;
		end else if (clr) begin
			ptr_ff <= '0; // [R4]
			ovr_ff <= 1'b0;
		end else begin
			ptr_ff <= nxt_ptr;
			if (push && !wr_ok) begin
				ovr_ff <= 1'b1;
			end
		end
	end
	// ============================================================
	// Almost-full flag.
	logic [PW-1:0] thr;          // Words that raise the flag.
	assign thr = PW'(cnt_sel_ff) + PW'(1); // [R12]
	// Set on conversion at threshold; cleared by disable or a falling count.
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			lnk.almost_full_flag_n <= 1'b1;
		end else if (clr) begin
			lnk.almost_full_flag_n <= 1'b1; // [R4]
		end else if (dis_ff || (wr_go && lnk.data_bus[`AFC_B_DIS])) begin
			lnk.almost_full_flag_n <= 1'b1; // [R18] [R21]
		end else if (push && nxt_ptr >= thr) begin
			lnk.almost_full_flag_n <= 1'b0; // [R10] [R11]
		end else if (pop && nxt_ptr < thr) begin
			lnk.almost_full_flag_n <= 1'b1; // [R17]
		end
	end
	// ============================================================
	// Read data path.
	logic [11:0]   stat;         // Status word.
	always_comb begin
		stat = 12'h0;
		stat[`AFC_B_ALMOST_FULL_FLAG_N] = lnk.almost_full_flag_n;
		stat[`AFC_B_CNT_HI:`AFC_B_CNT_LO] = cnt_sel_ff;
		stat[`AFC_B_DIS] = dis_ff;
		stat[`AFC_B_RST] = ovr_ff;
		stat[`AFC_B_BUS_ENABLE_DURING_BUSY] = |oor_v;
		stat[`AFC_B_EMP] = (ptr_ff == '0);
		stat[`AFC_B_SOOR] = oor_v[0];
		stat[2:0] = (ptr_ff == '0) ? 3'h0 : 3'(ptr_ff - PW'(1)); // [R13]
	end
	// Drive while read is active, unless blocked during busy.
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			lnk.dev_data_out  <= 12'h0;
			lnk.dev_data_oe_n <= 1'b1;
		end else begin
			lnk.dev_data_oe_n <= !(rd && !(busy_nxt && !bus_enable_during_busy_ff)); // [R19]
			lnk.dev_data_out  <= lnk.register_select ? stat : mem_ff[0][11:0]; // [R6] [R13] [R16]
		end
	end
endmodule // afc_dev

//--- rtl/afc_host.sv
`include "afc_cfg.svh"
module afc_host #(
	parameter int STROBE_CYC = `AFC_STROBE_CYC // Strobe low cycles.
) (
	// Clock and reset.
	input  wire logic        REF_CLK_I,
	input  wire logic        RST_I,
	// Wishbone slave.
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [3:0]  WB_ADR_I,
	input  wire logic [31:0] WB_DAT_I,
	input  wire logic [3:0]  WB_SEL_I,
	output      logic [31:0] WB_DAT_O,
	output      logic        WB_ACK_O,
	// Processor link.
	afc_link_if.host         lnk
);
	// ============================================================
	// Wishbone registers.
	logic        req;            // New bus request this cycle.
	logic [11:0] wdata_ff;       // Control word to write.
	logic [11:0] rdata_ff;       // Last word read.
	logic [4:0]  cmd_ff;         // Pending command.
	logic        go_ff;          // Command launch pulse.
	afc_pkg::afc_hs_t hs_ff;     // Link cycle state.
	logic [7:0]  tmr_ff;         // Strobe timer.
	logic        act;            // Link strobes active in the coming cycle.
	assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	// Answer one cycle after the request; unmapped reads give zero.
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0;
			wdata_ff <= 12'h0;
			cmd_ff   <= 5'h0;
			go_ff    <= 1'b0;
		end else begin
			WB_ACK_O <= req;
			go_ff    <= 1'b0;
			if (req && WB_WE_I) begin
				if (WB_ADR_I == `AFC_WB_CMD && WB_SEL_I[0] && hs_ff == afc_pkg::HS_IDLE) begin
					cmd_ff <= WB_DAT_I[4:0];
					go_ff  <= |WB_DAT_I[4:0];
				end
				if (WB_ADR_I == `AFC_WB_WDATA) begin
					if (WB_SEL_I[0]) begin
						wdata_ff[7:0] <= WB_DAT_I[7:0];
					end
					if (WB_SEL_I[1]) begin
						wdata_ff[11:8] <= WB_DAT_I[11:8];
					end
				end
			end
			if (req && !WB_WE_I) begin
				unique case (WB_ADR_I)
					`AFC_WB_WDATA: WB_DAT_O <= {20'h0, wdata_ff};
					`AFC_WB_RDATA: WB_DAT_O <= {20'h0, rdata_ff};
					`AFC_WB_STAT:  WB_DAT_O <= {29'h0, lnk.busy_n, lnk.almost_full_flag_n,
						hs_ff != afc_pkg::HS_IDLE || go_ff};
					default:       WB_DAT_O <= 32'h0;
				endcase
			end
		end
	end
	// ============================================================
	// Link cycle sequencer.
	// One command at a time: strobes low for STROBE_CYC, then one idle cycle.
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			hs_ff    <= afc_pkg::HS_IDLE;
			tmr_ff   <= 8'h0;
			rdata_ff <= 12'h0;
		end else begin
			unique case (hs_ff)
				afc_pkg::HS_IDLE: begin
					if (go_ff) begin
						hs_ff  <= afc_pkg::HS_STRB;
						tmr_ff <= 8'(STROBE_CYC - 1);
					end
				end
				afc_pkg::HS_STRB: begin
					if (tmr_ff == 8'h0) begin
						hs_ff <= afc_pkg::HS_RCVR;
						if (cmd_ff[`AFC_CMD_RDFIFO] || cmd_ff[`AFC_CMD_RDSTAT]) begin
							rdata_ff <= lnk.data_bus;
						end
					end else begin
						tmr_ff <= tmr_ff - 8'h1;
					end
				end
				afc_pkg::HS_RCVR: begin
					hs_ff <= afc_pkg::HS_IDLE;
				end
			endcase
		end
	end
	// Pin drive from the command and state.
	assign act = (hs_ff == afc_pkg::HS_IDLE && go_ff) || (hs_ff == afc_pkg::HS_STRB && tmr_ff != 8'h0);
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			lnk.conversion_start_n <= 1'b1;
			lnk.reset_n            <= 1'b1;
			lnk.cs_n               <= 1'b1;
			lnk.read_strobe_n      <= 1'b1;
			lnk.write_strobe_n     <= 1'b1;
			lnk.register_select    <= 1'b0;
			lnk.host_data_out      <= 12'h0;
			lnk.host_data_oe_n     <= 1'b1;
		end else begin
			lnk.conversion_start_n <= !(act && cmd_ff[`AFC_CMD_CONV]);
			lnk.reset_n            <= !(act && cmd_ff[`AFC_CMD_RESET]);
			lnk.cs_n               <= !(act && |cmd_ff[`AFC_CMD_WRCTRL:`AFC_CMD_RDFIFO]);
			lnk.read_strobe_n      <= !(act && (cmd_ff[`AFC_CMD_RDFIFO] || cmd_ff[`AFC_CMD_RDSTAT]));
			lnk.write_strobe_n     <= !(act && cmd_ff[`AFC_CMD_WRCTRL]);
			lnk.register_select    <= act && (cmd_ff[`AFC_CMD_RDSTAT] || cmd_ff[`AFC_CMD_WRCTRL]); // [R7]
			lnk.host_data_out      <= wdata_ff;
			lnk.host_data_oe_n     <= !(act && cmd_ff[`AFC_CMD_WRCTRL]);
		end
	end
endmodule // afc_host

//--- tb/afc_props.sv
// ============================================================
// Link checker: watches the wire between processor and converter.
module afc_props #(
	parameter int BUSY_CYC = 2 // Track/hold settle cycles of the converter.
) (
	// Clock and reset.
	input wire logic        REF_CLK_I,
	input wire logic        RST_I,
	// Link signals.
	input wire logic        conversion_start_n,
	input wire logic        reset_n,
	input wire logic        cs_n,
	input wire logic        read_strobe_n,
	input wire logic        write_strobe_n,
	input wire logic        register_select,
	input wire logic        busy_n,
	input wire logic        almost_full_flag_n,
	input wire logic        dev_data_oe_n,
	input wire logic [11:0] data_bus
);
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (RST_I);
	logic       bus_enable_during_busy_ff;  // Last written bus-during-busy bit.
	logic       dis_ff;   // Last written flag disable bit.
	logic [7:0] busy_ff;  // Cycles spent with busy low.
	// ============================================================
	// Shadow the control bits; a link reset or a bit-6 write clears them.
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			bus_enable_during_busy_ff <= 1'b0;
			dis_ff  <= 1'b0;
		end else if (!reset_n) begin
			bus_enable_during_busy_ff <= 1'b0;
			dis_ff  <= 1'b0;
		end else if (!cs_n && !write_strobe_n && register_select) begin
			bus_enable_during_busy_ff <= data_bus[5] && !data_bus[6];
			dis_ff  <= data_bus[7] && !data_bus[6];
		end
	end
	// Count the length of each busy pulse.
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			busy_ff <= 8'h00;
		end else begin
			busy_ff <= busy_n ? 8'h00 : busy_ff + 8'h01;
		end
	end
	// ============================================================
	// Named steps of a bus access.
	sequence s_rd_start;
		$fell(read_strobe_n) && !cs_n && busy_n && bus_enable_during_busy_ff;
	endsequence
	sequence s_stat_rd;
		$fell(read_strobe_n) && !cs_n && register_select;
	endsequence
	sequence s_dis_wr;
		$fell(write_strobe_n) && !cs_n && register_select && data_bus[7] && !data_bus[6];
	endsequence
	property p_start_busy;
		$rose(conversion_start_n) && reset_n |-> ##[2:6] !busy_n;
	endproperty
	property p_busy_len;
		$rose(busy_n) |-> busy_ff == BUSY_CYC;
	endproperty
	property p_reset_flag;
		!reset_n |=> almost_full_flag_n;
	endproperty
	property p_read_answer;
		s_rd_start ##1 busy_n |-> !dev_data_oe_n;
	endproperty
	property p_drive_only_read;
		!dev_data_oe_n |-> !$past(cs_n) && !$past(read_strobe_n);
	endproperty
	property p_bus_enable_during_busy;
		!busy_n && !bus_enable_during_busy_ff |-> dev_data_oe_n;
	endproperty
	property p_dis_wr;
		s_dis_wr |-> ##[1:4] almost_full_flag_n;
	endproperty
	property p_dis_hold;
		dis_ff && $past(dis_ff, 3) |-> almost_full_flag_n;
	endproperty
	property p_stat_rd_keep;
		s_stat_rd |-> $stable(almost_full_flag_n)[*5];
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("busy did not follow start edge");
	a_busy_len: assert property (p_busy_len) else $error("busy pulse length wrong");
	a_reset_flag: assert property (p_reset_flag) else $error("flag low after reset");
	a_read_answer: assert property (p_read_answer) else $error("read not answered");
	a_drive_only_read: assert property (p_drive_only_read) else $error("bus driven without read");
	a_bus_enable_during_busy: assert property (p_bus_enable_during_busy) else $error("bus driven while busy");
	a_dis_wr: assert property (p_dis_wr) else $error("flag kept after disable");
	a_dis_hold: assert property (p_dis_hold) else $error("flag low while disabled");
	a_stat_rd_keep: assert property (p_stat_rd_keep) else $error("status read moved flag");
endmodule // afc_props

//--- tb/adc_fifo_status_control_test.sv
// ============================================================
// Bench: Wishbone orders to the host end, converter end behind it.
module adc_fifo_status_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BUSY = 30; // Lengthened settle time.
	localparam int CONV = 60; // Shortened conversion time.
	logic        ref_clk, rst, wb_cyc, wb_stb, wb_we, wb_ack, hold, oor, flag_n;
	logic [3:0]  wb_adr, wb_sel;
	logic [31:0] wb_wdat, wb_rdat;
	logic [11:0] sample;
	int          failures, checks_done, cycles;
	afc_link_if afc_link_if_i ();
	assign flag_n = afc_link_if_i.almost_full_flag_n;
	afc_dev #(.BUSY_CYC(BUSY), .CONV_CYC(CONV)) afc_dev_i (.REF_CLK_I(ref_clk), .RST_I(rst), .SAMPLE_I(sample),
		.SAMPLE_OOR_I(oor), .HOLD_O(hold), .lnk(afc_link_if_i));
	afc_host #(.STROBE_CYC(3)) afc_host_i (.REF_CLK_I(ref_clk), .RST_I(rst), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb),
		.WB_WE_I(wb_we), .WB_ADR_I(wb_adr), .WB_DAT_I(wb_wdat), .WB_SEL_I(wb_sel), .WB_DAT_O(wb_rdat),
		.WB_ACK_O(wb_ack), .lnk(afc_link_if_i));
	afc_props #(.BUSY_CYC(BUSY)) afc_props_i (.REF_CLK_I(ref_clk), .RST_I(rst),
		.conversion_start_n(afc_link_if_i.conversion_start_n), .reset_n(afc_link_if_i.reset_n),
		.cs_n(afc_link_if_i.cs_n), .read_strobe_n(afc_link_if_i.read_strobe_n),
		.write_strobe_n(afc_link_if_i.write_strobe_n), .register_select(afc_link_if_i.register_select),
		.busy_n(afc_link_if_i.busy_n), .almost_full_flag_n(flag_n),
		.dev_data_oe_n(afc_link_if_i.dev_data_oe_n), .data_bus(afc_link_if_i.data_bus));
	// ============================================================
	// Clock and hang guard.
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			close_out();
		end
	end
	// Print the counts and the verdict, then stop.
	task automatic close_out();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Compare one value with its expectation.
	task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// ============================================================
	// One classic Wishbone cycle; the request stands until ack is seen.
	task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge ref_clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_sel <= 4'hf;
		wb_wdat <= d;
		do @(posedge ref_clk); while (wb_ack !== 1'b1);
		q = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask
	// Issue a command and poll until the link is idle again.
	task automatic cmd(input logic [4:0] bits);
		logic [31:0] q;
		wb(1'b1, 4'h0, {27'h0, bits}, q);
		do wb(1'b0, 4'hc, 32'h0, q); while (q[0] !== 1'b0);
	endtask
	// Read the status register (sel high) or FIFO word 0 (sel low).
	task automatic lrd(input logic sel, output logic [11:0] w);
		logic [31:0] q;
		cmd(sel ? 5'h04 : 5'h02);
		wb(1'b0, 4'h8, 32'h0, q);
		w = q[11:0];
		repeat (2) @(posedge ref_clk);
	endtask
	// Write the control register over the link.
	task automatic ctl(input logic [11:0] v);
		logic [31:0] q;
		wb(1'b1, 4'h4, {20'h0, v}, q);
		cmd(5'h08);
	endtask
	// Run one conversion of the given sample to its end.
	task automatic conv(input logic [11:0] s, input logic o);
		sample <= s;
		oor <= o;
		cmd(5'h01);
		do @(posedge ref_clk); while (hold !== 1'b1);
		do @(posedge ref_clk); while (hold !== 1'b0);
		@(posedge ref_clk);
	endtask
	// ============================================================
	// Scenarios.
	task automatic t_reset();
		logic [11:0] w;
		lrd(1'b1, w);
		chk(w, 12'h810);
		lrd(1'b0, w);
		chk(w, 12'h800);
		chk({11'h0, flag_n}, 12'h001);
	endtask
	// Fill to the threshold, read status twice, pop, then disable the flag.
	task automatic t_fill();
		logic [11:0] w;
		ctl(12'h220);
		conv(12'h123, 1'b1);
		conv(12'h456, 1'b0);
		chk({11'h0, flag_n}, 12'h001);
		conv(12'h789, 1'b0);
		chk({11'h0, flag_n}, 12'h000);
		lrd(1'b1, w);
		chk(w, 12'h22a);
		lrd(1'b1, w);
		chk(w, 12'h22a);
		lrd(1'b0, w);
		chk(w, 12'h123);
		chk({11'h0, flag_n}, 12'h001);
		lrd(1'b1, w);
		chk({9'h0, w[2:0]}, 12'h001);
		lrd(1'b0, w);
		chk(w, 12'h456);
		conv(12'h0ab, 1'b0);
		conv(12'h0cd, 1'b0);
		chk({11'h0, flag_n}, 12'h000);
		ctl(12'h2a0);
		chk({11'h0, flag_n}, 12'h001);
		lrd(1'b1, w);
		chk({11'h0, w[11]}, 12'h001);
	endtask
	// Link reset pulse and the bit-6 reset both clear FIFO and register.
	task automatic t_clear();
		logic [11:0] w;
		cmd(5'h10);
		lrd(1'b1, w);
		chk(w, 12'h810);
		lrd(1'b0, w);
		chk(w, 12'h800);
		conv(12'h5a5, 1'b1);
		ctl(12'h040);
		lrd(1'b1, w);
		chk(w, 12'h810);
		lrd(1'b0, w);
		chk(w, 12'h800);
	endtask
	// Both ends of the threshold range: one word and eight words.
	task automatic t_thresh();
		for (int c = 0; c < 8; c += 7) begin
			cmd(5'h10);
			ctl({1'b0, c[2:0], 8'h20});
			for (int i = 0; i <= c; i++) begin
				conv(12'(i + 16), 1'b0);
				chk({11'h0, flag_n}, (i == c) ? 12'h000 : 12'h001);
			end
		end
	endtask
	// Status reads during busy: served with bit 5 set, withheld with it clear.
	task automatic t_bus_enable_during_busy();
		logic [11:0] w;
		cmd(5'h10);
		ctl(12'h020);
		cmd(5'h01);
		lrd(1'b1, w);
		chk(w, 12'h810);
		do @(posedge ref_clk); while (hold !== 1'b0);
		ctl(12'h000);
		cmd(5'h01);
		lrd(1'b1, w);
		chk(w, 12'hfff);
		do @(posedge ref_clk); while (hold !== 1'b0);
	endtask
	// ============================================================
	// Main sequence.
	initial begin
		rst = 1'b1;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 4'h0;
		wb_sel = 4'h0;
		wb_wdat = 32'h0;
		sample = 12'h000;
		oor = 1'b0;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset();
		t_fill();
		t_clear();
		t_thresh();
		t_bus_enable_during_busy();
		close_out();
	end
endmodule // adc_fifo_status_control_test
